//--- rtl/isrs_pkg.sv
// Constants and types of the interrupt, stack and reset sequencer.
// Behaviour
// - Stack pointer names next free byte.
// - 128-byte stack, nine upper bits fixed.
// - Reset or reload sets low pointer byte.
// - Pointer wraps both ways, no overflow flag.
// - Call takes two bytes, interrupt five.
// - Every reset source fetches the top vector.
// - Hold 4096 cycles after oscillator starts.
// - Drive reset pin low on internal resets.
// - Entry finishes instruction, pushes context, masks, vectors.
// - Return pops context and restores mask.
// - Masked requests wait latched until unmasked.
// - Fixed priority order among pending requests.
// - Software trap ignores the mask flag.
// - Lines 1,2,5,6 rising; 3,4,7,8 falling.
// - Edge request needs line enable, mask clear.
// - Peripheral flag needs enable; else stays pending.
// - Clear by writing zero or access sequence.
// - Clear sequence discards not-yet-enabled pending request.
// - Wait wakes on any; Halt on few.
// - Edge enables at 0008h, cleared on reset.
// - Second index register is never stacked.
// - Mask flag is condition bit 3.
package isrs_pkg;
    localparam int unsigned STARTUP_CYC = 4096;
    localparam logic [12:0] STARTUP_LAST = 13'(STARTUP_CYC - 1);
    localparam logic [8:0] STK_HI = 9'h003;
    localparam logic [6:0] STK_TOP = 7'h7f;
    localparam logic [15:0] VEC_RESET = 16'hfffe;
    localparam logic [15:0] VEC_TRAP = 16'hfffc;
    localparam logic [15:0] VEC_SRC0 = 16'hfffa;
    localparam int unsigned CC_MASK_BIT = 3;
    localparam int unsigned NSRC = 7;
    localparam int unsigned SRC_EXT = 2;
    localparam int unsigned SRC_TIMER = 3;
    localparam logic [6:0] SRC_IMPL = 7'h6f;
    localparam logic [6:0] HALT_WAKE = 7'h07;
    localparam logic [7:0] EDGE_FALL = 8'hcc;
    localparam logic [6:0] CTRL_RST = 7'h00;
    localparam logic [7:0] EDGE_EN_RST = 8'h00;
    localparam logic [2:0] PUSH_LAST = 3'h4;
    localparam logic [2:0] POP_ISSUE_LAST = 3'h4;
    localparam logic [2:0] POP_FIRST_DATA = 3'h2;
    localparam logic [2:0] POP_LAST = 3'h6;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_EDGE_EN = 8'h08;
    localparam logic [7:0] ADDR_ASSOC = 8'h0c;
    localparam logic [7:0] ADDR_STACK = 8'h10;
    localparam int unsigned STACK_MASK_POS = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {R_CTRL, R_STATUS, R_EDGE_EN, R_ASSOC, R_STACK, R_NONE} isrs_reg_t;
    typedef enum logic [3:0] {S_RST, S_DLY, S_RUN, S_PUSH, S_VEC, S_POP, S_WAIT, S_HALT, S_HDLY} isrs_state_t;

    typedef struct packed {
        logic [15:0] pc;
        logic [7:0] x;
        logic [7:0] a;
        logic [7:0] cc;
    } isrs_ctx_t;

    typedef struct packed {
        logic boundary;
        logic push;
        logic pop;
        logic stack_reload_op;
        logic trap;
        logic return_from_handler;
        logic wait_op;
        logic halt_op;
        logic mask_set;
        logic mask_clr;
        logic [7:0] push_data;
    } isrs_core_op_t;

    typedef struct packed {
        logic we;
        logic re;
        logic [15:0] addr;
        logic [7:0] wdata;
    } isrs_stk_t;

    typedef struct packed {
        logic valid;
        isrs_ctx_t ctx;
    } isrs_restore_t;
endpackage : isrs_pkg

//--- rtl/isrs_top.sv
// Interrupt, stack pointer and reset sequencer with an AXI4-Lite register slave.
`timescale 1ns/1ps
module isrs_top (
    input wire logic mclk,
    input wire logic rst,
    input wire isrs_pkg::isrs_core_op_t core_op,
    input wire isrs_pkg::isrs_ctx_t ctx,
    input wire logic [7:0] stk_rdata,
    input wire logic [6:0] perif_evt,
    input wire logic [7:0] edge_input_line,
    input wire logic supply_drop_reset,
    input wire logic wdg_req,
    input wire logic rst_n_pin_in,
    output logic rst_n_pin_out,
    output logic rst_n_pin_oe_n,
    output logic core_rst,
    output logic busy,
    output logic mask_flag,
    output logic [15:0] stack_pointer,
    output isrs_pkg::isrs_stk_t stk,
    output logic vec_fetch,
    output logic [15:0] vec_addr,
    output isrs_pkg::isrs_restore_t restore,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import isrs_pkg::*;

    function automatic isrs_reg_t reg_sel(input logic [31:0] addr);
        isrs_reg_t r;
        r = R_NONE;
        if (addr[31:8] == 24'h000000) begin
            case (addr[7:0])
                ADDR_CTRL: r = R_CTRL;
                ADDR_STATUS: r = R_STATUS;
                ADDR_EDGE_EN: r = R_EDGE_EN;
                ADDR_ASSOC: r = R_ASSOC;
                ADDR_STACK: r = R_STACK;
                default: r = R_NONE;
            endcase
        end
        return r;
    endfunction : reg_sel

    // Lowest index wins: flash, end-suspend, edge lines, timer, reserved, serial, bus.
    function automatic logic [2:0] prio(input logic [6:0] r);
        logic [2:0] p;
        p = 3'h0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (r[i]) begin
                p = 3'(i);
            end
        end
        return p;
    endfunction : prio

    // The second index register has no slot in the frame.
    function automatic logic [7:0] push_byte(input logic [2:0] n, input isrs_ctx_t c);
        logic [7:0] b;
        case (n)
            3'h0: b = c.pc[7:0];
            3'h1: b = c.pc[15:8];
            3'h2: b = c.x;
            3'h3: b = c.a;
            default: b = c.cc;
        endcase
        return b;
    endfunction : push_byte

    isrs_state_t state_ff, nxt_state;
    logic [2:0] cnt_ff;
    logic [12:0] dly_ff;
    logic [6:0] sp_lo_ff;
    logic mask_ff;
    logic [6:0] pend_ff, ctrl_ff, arm_ff;
    logic [7:0] edge_en_ff, ln_s1_ff, ln_s2_ff, ln_prev_ff, edge_evt;
    logic lvd_s1_ff, lvd_s2_ff, pin_s1_ff, pin_s2_ff;
    logic [1:0] drv_hist_ff;
    isrs_ctx_t ctx_cap_ff;
    logic [15:0] vec_sel_ff;
    logic aw_got_ff, w_got_ff;
    logic [31:0] waddr_ff, wdata_ff;
    logic [3:0] wstrb_ff;

    // Pin and supply inputs are asynchronous to mclk.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ln_s1_ff <= 8'h00;
            ln_s2_ff <= 8'h00;
            ln_prev_ff <= 8'h00;
            lvd_s1_ff <= 1'b0;
            lvd_s2_ff <= 1'b0;
            pin_s1_ff <= 1'b1;
            pin_s2_ff <= 1'b1;
        end else begin
            ln_s1_ff <= edge_input_line;
            ln_s2_ff <= ln_s1_ff;
            ln_prev_ff <= ln_s2_ff;
            lvd_s1_ff <= supply_drop_reset;
            lvd_s2_ff <= lvd_s1_ff;
            pin_s1_ff <= rst_n_pin_in;
            pin_s2_ff <= pin_s1_ff;
        end
    end

    for (genvar i = 0; i < 8; i++) begin : g_edge
        assign edge_evt[i] = EDGE_FALL[i] ? (~ln_s2_ff[i] & ln_prev_ff[i]) : (ln_s2_ff[i] & ~ln_prev_ff[i]);
    end

    // Our own drive is seen on the pin two cycles late, so the pin is ignored that long.
    logic ext_rst, src_rst, run, svc, trap_sel, entry;
    logic [6:0] en_vec, req, pend_set, pend_clr;
    logic [2:0] sel_src;
    assign ext_rst = ~pin_s2_ff & rst_n_pin_oe_n & ~|drv_hist_ff;
    assign src_rst = lvd_s2_ff | wdg_req | ext_rst;
    assign run = (state_ff == S_RUN);
    assign en_vec = ctrl_ff | (7'h01 << SRC_EXT);
    assign req = pend_ff & en_vec & SRC_IMPL;
    assign trap_sel = run & core_op.boundary & core_op.trap;
    assign svc = run & core_op.boundary & (core_op.trap | (~mask_ff & |req));
    assign sel_src = prio(req);
    assign entry = (nxt_state == S_PUSH) & (state_ff != S_PUSH);

    always_comb begin
        nxt_state = state_ff;
        if (src_rst) begin
            nxt_state = S_RST;
        end else begin
            case (state_ff)
                S_RST: nxt_state = S_DLY;
                S_DLY: if (dly_ff == STARTUP_LAST) nxt_state = S_VEC;
                S_RUN: begin
                    if (svc) begin
                        nxt_state = S_PUSH;
                    end else if (core_op.boundary & core_op.return_from_handler) begin
                        nxt_state = S_POP;
                    end else if (core_op.boundary & core_op.wait_op) begin
                        nxt_state = S_WAIT;
                    end else if (core_op.boundary & core_op.halt_op) begin
                        nxt_state = S_HALT;
                    end
                end
                S_PUSH: if (cnt_ff == PUSH_LAST) nxt_state = S_VEC;
                S_VEC: nxt_state = S_RUN;
                S_POP: if (cnt_ff == POP_LAST) nxt_state = S_RUN;
                S_WAIT: if (|req) nxt_state = S_PUSH;
                S_HALT: if (|(req & HALT_WAKE)) nxt_state = S_HDLY;
                S_HDLY: if (dly_ff == STARTUP_LAST) nxt_state = S_PUSH;
                default: nxt_state = S_RST;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_ff <= S_RST;
            cnt_ff <= 3'h0;
            dly_ff <= 13'h0000;
            busy <= 1'b1;
            core_rst <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= (nxt_state == state_ff) ? cnt_ff + 3'h1 : 3'h0;
            dly_ff <= (nxt_state == state_ff) ? dly_ff + 13'h0001 : 13'h0000;
            busy <= (nxt_state != S_RUN);
            core_rst <= (nxt_state == S_RST) | (nxt_state == S_DLY);
        end
    end

    // Context and vector are frozen at entry so a late change cannot tear the frame.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctx_cap_ff <= '0;
            vec_sel_ff <= VEC_RESET;
        end else if (state_ff == S_RST) begin
            vec_sel_ff <= VEC_RESET;
        end else if (entry) begin
            ctx_cap_ff <= ctx;
            ctx_cap_ff.cc[CC_MASK_BIT] <= mask_ff;
            vec_sel_ff <= trap_sel ? VEC_TRAP : VEC_SRC0 - {12'h000, sel_src, 1'b0};
        end
    end

    logic core_push_ok, core_pop_ok, pop_step;
    assign core_push_ok = run & core_op.push & ~svc;
    assign core_pop_ok = run & core_op.pop & ~core_op.push & ~svc;
    assign pop_step = core_pop_ok | ((state_ff == S_POP) & (cnt_ff <= POP_ISSUE_LAST));

    // Seven-bit arithmetic gives the wrap at both ends without any flag.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sp_lo_ff <= STK_TOP;
        end else if ((state_ff == S_RST) | (run & core_op.stack_reload_op)) begin
            sp_lo_ff <= STK_TOP;
        end else if (core_push_ok | (state_ff == S_PUSH)) begin
            sp_lo_ff <= sp_lo_ff - 7'h01;
        end else if (pop_step) begin
            sp_lo_ff <= sp_lo_ff + 7'h01;
        end
    end
    assign stack_pointer = {STK_HI, sp_lo_ff};

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stk <= '0;
        end else begin
            stk.we <= core_push_ok | (state_ff == S_PUSH);
            stk.re <= pop_step;
            stk.addr <= {STK_HI, pop_step ? sp_lo_ff + 7'h01 : sp_lo_ff};
            stk.wdata <= core_push_ok ? core_op.push_data : push_byte(cnt_ff, ctx_cap_ff);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            vec_fetch <= 1'b0;
            vec_addr <= VEC_RESET;
        end else begin
            vec_fetch <= (state_ff == S_VEC);
            if (state_ff == S_VEC) begin
                vec_addr <= vec_sel_ff;
            end
        end
    end

    // Popped in reverse: flags, accumulator, index, counter high, counter low.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            restore <= '0;
        end else begin
            restore.valid <= (state_ff == S_POP) & (cnt_ff == POP_LAST);
            if ((state_ff == S_POP) & (cnt_ff >= POP_FIRST_DATA)) begin
                case (cnt_ff)
                    3'h2: restore.ctx.cc <= stk_rdata;
                    3'h3: restore.ctx.a <= stk_rdata;
                    3'h4: restore.ctx.x <= stk_rdata;
                    3'h5: restore.ctx.pc[15:8] <= stk_rdata;
                    default: restore.ctx.pc[7:0] <= stk_rdata;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mask_ff <= 1'b1;
        end else if ((state_ff == S_RST) | (state_ff == S_VEC)) begin
            mask_ff <= 1'b1;
        end else if ((state_ff == S_POP) & (cnt_ff == POP_FIRST_DATA)) begin
            mask_ff <= stk_rdata[CC_MASK_BIT];
        end else if ((nxt_state == S_WAIT) | (nxt_state == S_HALT)) begin
            mask_ff <= 1'b0;
        end else if (run & core_op.mask_set) begin
            mask_ff <= 1'b1;
        end else if (run & core_op.mask_clr) begin
            mask_ff <= 1'b0;
        end
    end
    assign mask_flag = mask_ff;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rst_n_pin_oe_n <= 1'b1;
            rst_n_pin_out <= 1'b0;
            drv_hist_ff <= 2'h0;
        end else begin
            rst_n_pin_oe_n <= ~(lvd_s2_ff | wdg_req | (~rst_n_pin_oe_n & ((state_ff == S_RST) | (state_ff == S_DLY))));
            rst_n_pin_out <= 1'b0;
            drv_hist_ff <= {drv_hist_ff[0], ~rst_n_pin_oe_n};
        end
    end

    // Register bus: write address and data may come in either order.
    logic aw_take, w_take, wr_fire, ar_take, aw_nxt, w_nxt, b_nxt;
    isrs_reg_t wsel, rsel;
    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take = s_axi_wvalid & s_axi_wready;
    assign wr_fire = aw_got_ff & w_got_ff & ~s_axi_bvalid;
    assign ar_take = s_axi_arvalid & s_axi_arready;
    assign aw_nxt = aw_take | (aw_got_ff & ~wr_fire);
    assign w_nxt = w_take | (w_got_ff & ~wr_fire);
    assign b_nxt = wr_fire | (s_axi_bvalid & ~s_axi_bready);
    assign wsel = reg_sel(waddr_ff);
    assign rsel = reg_sel(s_axi_araddr);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            waddr_ff <= 32'h00000000;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                waddr_ff <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            aw_got_ff <= aw_nxt;
            w_got_ff <= w_nxt;
            s_axi_awready <= ~aw_nxt & ~b_nxt;
            s_axi_wready <= ~w_nxt & ~b_nxt;
            s_axi_bvalid <= b_nxt;
            if (wr_fire) begin
                s_axi_bresp <= (wsel == R_NONE) ? RESP_SLVERR : RESP_OKAY;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= (rsel == R_NONE) ? RESP_SLVERR : RESP_OKAY;
            case (rsel)
                R_CTRL: s_axi_rdata <= {25'h0000000, ctrl_ff};
                R_STATUS: s_axi_rdata <= {25'h0000000, pend_ff};
                R_EDGE_EN: s_axi_rdata <= {24'h000000, edge_en_ff};
                R_STACK: s_axi_rdata <= {15'h0000, mask_ff, stack_pointer};
                default: s_axi_rdata <= 32'h00000000;
            endcase
        end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_ff <= CTRL_RST;
            edge_en_ff <= EDGE_EN_RST;
        end else if (state_ff == S_RST) begin
            ctrl_ff <= CTRL_RST;
            edge_en_ff <= EDGE_EN_RST;
        end else if (wr_fire & wstrb_ff[0]) begin
            if (wsel == R_CTRL) begin
                ctrl_ff <= wdata_ff[6:0];
            end
            if (wsel == R_EDGE_EN) begin
                edge_en_ff <= wdata_ff[7:0];
            end
        end
    end

    // A status read arms the flags then set; the next associated access clears them.
    logic assoc_hit;
    assign assoc_hit = (wr_fire & (wsel == R_ASSOC)) | (ar_take & (rsel == R_ASSOC));
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            arm_ff <= 7'h00;
        end else if (ar_take & (rsel == R_STATUS)) begin
            arm_ff <= pend_ff;
        end else if (assoc_hit) begin
            arm_ff <= 7'h00;
        end
    end

    assign pend_set = (perif_evt & SRC_IMPL & ~(7'h01 << SRC_EXT)) | ({6'h00, |(edge_evt & edge_en_ff)} << SRC_EXT);
    assign pend_clr = ((wr_fire & wstrb_ff[0] & (wsel == R_STATUS)) ? ~wdata_ff[6:0] : 7'h00)
                    | (assoc_hit ? arm_ff : 7'h00)
                    | ((entry & ~trap_sel & (sel_src == 3'(SRC_EXT))) ? (7'h01 << SRC_EXT) : 7'h00);

    // A new event in the clearing cycle survives; only the selected edge request is consumed.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pend_ff <= 7'h00;
        end else if (state_ff == S_RST) begin
            pend_ff <= 7'h00;
        end else begin
            pend_ff <= (pend_ff & ~pend_clr) | pend_set;
        end
    end

    property p_sp_push;
        @(posedge mclk) disable iff (rst) core_push_ok |=> sp_lo_ff == $past(sp_lo_ff) - 7'h01;
    endproperty
    a_sp_push: assert property (p_sp_push) else $error("push did not lower the pointer");

    property p_sp_wrap;
        @(posedge mclk) disable iff (rst) (core_pop_ok && sp_lo_ff == STK_TOP) |=> stack_pointer == {STK_HI, 7'h00};
    endproperty
    a_sp_wrap: assert property (p_sp_wrap) else $error("pop at top did not wrap");

    property p_reload;
        @(posedge mclk) disable iff (rst) (state_ff == S_RST) |=> stack_pointer[7:0] == 8'hff;
    endproperty
    a_reload: assert property (p_reload) else $error("reset did not set low pointer bits");

    property p_entry;
        @(posedge mclk) disable iff (rst || src_rst) (run && entry) |-> ##2 (stk.we && stk.wdata == $past(ctx.pc[7:0], 2)
            && stk.addr == {STK_HI, $past(sp_lo_ff, 2)}) ##1 stk.we [*4] ##1 (!stk.we && vec_fetch && mask_ff);
    endproperty
    a_entry: assert property (p_entry) else $error("interrupt frame or vector wrong");

    property p_masked;
        @(posedge mclk) disable iff (rst) (run && mask_ff && !core_op.trap) |=> state_ff != S_PUSH;
    endproperty
    a_masked: assert property (p_masked) else $error("masked request was served");

    property p_trap;
        @(posedge mclk) disable iff (rst || src_rst) trap_sel |=> state_ff == S_PUSH ##6 (vec_fetch && vec_addr == VEC_TRAP);
    endproperty
    a_trap: assert property (p_trap) else $error("trap not entered");

    property p_edge;
        @(posedge mclk) disable iff (rst) (|(edge_evt & edge_en_ff) && state_ff != S_RST) |=> pend_ff[SRC_EXT];
    endproperty
    a_edge: assert property (p_edge) else $error("enabled edge not latched");

    property p_wr_clear;
        @(posedge mclk) disable iff (rst) (pend_clr[SRC_TIMER] && !pend_set[SRC_TIMER]) |=> !pend_ff[SRC_TIMER];
    endproperty
    a_wr_clear: assert property (p_wr_clear) else $error("timer flag not cleared");

    property p_pin;
        @(posedge mclk) disable iff (rst) (lvd_s2_ff || wdg_req) |=> (!rst_n_pin_oe_n && !rst_n_pin_out);
    endproperty
    a_pin: assert property (p_pin) else $error("reset pin not driven low");

    property p_delay;
        @(posedge mclk) disable iff (rst || src_rst) (state_ff == S_DLY && dly_ff == STARTUP_LAST) |=> state_ff == S_VEC
            ##1 (vec_fetch && vec_addr == VEC_RESET);
    endproperty
    a_delay: assert property (p_delay) else $error("reset vector not fetched after delay");

    property p_halt;
        @(posedge mclk) disable iff (rst || src_rst) (state_ff == S_HALT && !(|(req & HALT_WAKE))) |=> state_ff == S_HALT;
    endproperty
    a_halt: assert property (p_halt) else $error("halt left without wake source");

    property p_ret;
        @(posedge mclk) disable iff (rst) restore.valid |-> mask_ff == restore.ctx.cc[CC_MASK_BIT];
    endproperty
    a_ret: assert property (p_ret) else $error("mask not restored on return");
endmodule : isrs_top

//--- test/isrs_stack_ram.sv
// Stack memory model that answers a read one cycle after the strobe.
`timescale 1ns/1ps
module isrs_stack_ram (
    input wire logic mclk,
    input wire isrs_pkg::isrs_stk_t stk,
    output logic [7:0] stk_rdata
);
    import isrs_pkg::*;
    logic [7:0] mem_ff [0:127];
    // Between reads the data bus flips, so a pop that samples late reads garbage.
    always_ff @(posedge mclk) begin
        if (stk.we) mem_ff[stk.addr[6:0]] <= stk.wdata;
        stk_rdata <= stk.re ? mem_ff[stk.addr[6:0]] : ~stk_rdata;
    end
endmodule : isrs_stack_ram

//--- test/interrupt_stack_reset_sequencer_bench.sv
// Self-checking bench of the interrupt, stack and reset sequencer.
`timescale 1ns/1ps
module interrupt_stack_reset_sequencer_bench;
    import isrs_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic supply_drop_reset = 1'b0;
    logic wdg_req = 1'b0;
    logic ext_rst_n = 1'b1;
    isrs_core_op_t core_op = '0;
    isrs_ctx_t ctx = '{16'h1234, 8'h56, 8'h78, 8'hf0};
    logic [7:0] stk_rdata;
    logic [7:0] edge_input_line = 8'h00;
    logic [6:0] perif_evt = 7'h00;
    logic rst_n_pin_out, rst_n_pin_oe_n, core_rst, busy, mask_flag, vec_fetch;
    logic [15:0] stack_pointer, vec_addr;
    isrs_stk_t stk;
    isrs_restore_t restore;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    int err_count = 0, n_tests = 0, cyc = 0;
    // The pin has a pull-up, so it shows the board level unless the block pulls it down.
    wire rst_n_pin_in = rst_n_pin_oe_n ? ext_rst_n : rst_n_pin_out;
    isrs_top isrs_top_i (.*);
    isrs_stack_ram isrs_stack_ram_i (.*);
    always #50 mclk = ~mclk;
    always @(negedge mclk) cyc++;
    task automatic check(input string what, input logic [47:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic axi_wr(input logic [31:0] a, d);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        check("bresp", s_axi_bresp, RESP_OKAY);
    endtask : axi_wr
    task automatic axi_rd(input logic [31:0] a);
        @(posedge mclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_rd
    task automatic boot_chk(input int lo);
        int t0 = cyc;
        repeat (4300) if (vec_fetch !== 1'b1) @(posedge mclk);
        check("delay", (cyc - t0) >= lo, 1'b1);
        check("vec", vec_addr, VEC_RESET);
        check("fetch", vec_fetch, 1'b1);
        check("core_rst", core_rst, 1'b0);
        check("sp", stack_pointer, 16'h01ff);
        check("pin_oe_n", rst_n_pin_oe_n, 1'b1);
    endtask : boot_chk
    task automatic entry_chk(input logic [15:0] va, input logic [7:0] ccx);
        repeat (40) if (vec_fetch !== 1'b1) @(posedge mclk);
        check("vec", vec_addr, va);
        check("sp", stack_pointer, 16'h01fa);
        check("mask", mask_flag, 1'b1);
        check("pcl", isrs_stack_ram_i.mem_ff[127], 8'h34);
        check("cc", isrs_stack_ram_i.mem_ff[123], ccx);
        check("busy", busy, 1'b0);
    endtask : entry_chk
    task automatic ret_chk(input logic [7:0] ccx);
        core_op.return_from_handler <= 1'b1;
        @(posedge mclk);
        core_op.return_from_handler <= 1'b0;
        repeat (20) if (restore.valid !== 1'b1) @(posedge mclk);
        check("ctx", restore, {1'b1, ctx.pc, ctx.x, ctx.a, ccx});
        check("sp", stack_pointer, 16'h01ff);
        check("mask", mask_flag, ccx[3]);
    endtask : ret_chk
    task automatic t_edges;
        axi_wr(32'h8, 32'h5);
        axi_rd(32'h8);
        check("edge_en", rd, 32'h5);
        axi_rd(32'h40);
        check("unmapped", rr, RESP_SLVERR);
        core_op.mask_clr <= 1'b1;
        @(posedge mclk);
        core_op.mask_clr <= 1'b0;
        edge_input_line <= 8'h05;
        entry_chk(16'hfff6, 8'hf0);
        ret_chk(8'hf0);
        repeat (10) @(posedge mclk);
        check("no_entry", stack_pointer, 16'h01ff);
        core_op.wait_op <= 1'b1;
        @(posedge mclk);
        core_op.wait_op <= 1'b0;
        edge_input_line <= 8'h01;
        entry_chk(16'hfff6, 8'hf0);
        ret_chk(8'hf0);
        $display("edge lines done");
    endtask : t_edges
    task automatic t_trap;
        core_op.mask_set <= 1'b1;
        @(posedge mclk);
        core_op.mask_set <= 1'b0;
        edge_input_line <= 8'h00;
        repeat (4) @(posedge mclk);
        edge_input_line <= 8'h01;
        repeat (4) @(posedge mclk);
        core_op.trap <= 1'b1;
        @(posedge mclk);
        core_op.trap <= 1'b0;
        entry_chk(VEC_TRAP, 8'hf8);
        ret_chk(8'hf8);
        core_op.mask_clr <= 1'b1;
        @(posedge mclk);
        core_op.mask_clr <= 1'b0;
        entry_chk(16'hfff6, 8'hf0);
        ret_chk(8'hf0);
        $display("trap and latch done");
    endtask : t_trap
    task automatic t_wdg;
        perif_evt <= 7'h08;
        @(posedge mclk);
        perif_evt <= 7'h00;
        axi_rd(32'h4);
        check("pend", rd, 32'h8);
        axi_wr(32'h4, 32'h0);
        axi_rd(32'h4);
        check("pend_clr", rd, 32'h0);
        core_op.pop <= 1'b1;
        @(posedge mclk);
        core_op.pop <= 1'b0;
        repeat (2) @(posedge mclk);
        check("pop_sp", stack_pointer, 16'h0180);
        core_op.push <= 1'b1;
        repeat (2) @(posedge mclk);
        core_op.push <= 1'b0;
        repeat (2) @(posedge mclk);
        check("push_sp", stack_pointer, 16'h01fe);
        wdg_req <= 1'b1;
        @(posedge mclk);
        wdg_req <= 1'b0;
        repeat (4) @(posedge mclk);
        check("pin_oe_n", rst_n_pin_oe_n, 1'b0);
        boot_chk(4080);
        axi_rd(32'h8);
        check("edge_en", rd, 32'h0);
        ext_rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        ext_rst_n <= 1'b1;
        boot_chk(4000);
        $display("reset sources done");
    endtask : t_wdg
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        boot_chk(4096);
        $display("power-up done");
        core_op.boundary <= 1'b1;
        t_edges();
        t_trap();
        t_wdg();
        tally_and_finish();
    end
    initial begin
        #3000000;
        err_count++;
        tally_and_finish();
    end
endmodule : interrupt_stack_reset_sequencer_bench
